// file: core/pwc_pkg.sv
// Package for the power-on reset and power-down/wake control block
package pwc_pkg;

  localparam int unsigned CLK_HZ = 20000000;

  // Timing constants in their own units, converted to cycles
  localparam int unsigned POR_DELAY_MS = 128;
  localparam int unsigned POR_DELAY_CYC = POR_DELAY_MS * (CLK_HZ / 1000);
  localparam int unsigned LOCK_DELAY_US = 1000;
  localparam int unsigned LOCK_DELAY_CYC = LOCK_DELAY_US * (CLK_HZ / 1000000);
  localparam int unsigned XTAL_DELAY_MS = 150;
  localparam int unsigned XTAL_DELAY_CYC = XTAL_DELAY_MS * (CLK_HZ / 1000);
  localparam int unsigned PLL_MULT = 384;
  localparam int unsigned OSC_HZ = 32768;

  // APB register byte offsets
  localparam logic [7:0] PWR_CTRL_OFF = 8'h00;
  localparam logic [7:0] PLL_CTRL_OFF = 8'h04;
  localparam logic [7:0] WAKE_EN_OFF = 8'h08;
  localparam logic [7:0] STATUS_OFF = 8'h0C;

  // power_control_reg fields
  localparam int unsigned PWR_DOWN_BIT = 1;
  localparam int unsigned EXT0_WAKE_BIT = 5;
  localparam int unsigned SERIAL_WAKE_BIT = 6;
  // pll_control_reg fields
  localparam int unsigned CDIV_LSB = 0;
  localparam int unsigned CDIV_W = 3;
  localparam int unsigned OSC_SLEEP_BIT = 3;
  localparam int unsigned LOCK_BIT = 6;
  // wake enable register: interrupt enables and interval counter run
  localparam int unsigned TIC_IE_BIT = 0;
  localparam int unsigned SPI_IE_BIT = 1;
  localparam int unsigned EXT0_IE_BIT = 2;
  localparam int unsigned TIC_RUN_BIT = 3;

  localparam logic [7:0] PWR_CTRL_RST = 8'h00;
  localparam logic [7:0] PLL_CTRL_RST = 8'h03;
  localparam logic [7:0] WAKE_EN_RST = 8'h00;

  typedef struct packed {
    logic tic_irq;
    logic spi_irq;
    logic ext0_irq;
  } pwc_wake_src_t;

  typedef struct packed {
    logic osc_run;
    logic pll_run;
    logic core_clk_en;
    logic periph_en;
    logic tic_en;
    logic dac_hiz;
    logic strobes_low;
    logic port_hold;
  } pwc_power_ctl_t;

endpackage

// file: core/pwc_delay_timer.sv
// Loadable down-counter that reports expiry of a start-up delay
`timescale 1ns/10ps
`default_nettype none
module pwc_delay_timer #(
  parameter int unsigned WIDTH = 32
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Control
  input wire logic load,
  input wire logic [WIDTH-1:0] load_val,
  input wire logic hold,
  // Status
  output logic done
);

  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;
  wire logic at_zero = (cnt_q == '0);

  assign cnt_d = load ? load_val :
                 (hold || at_zero) ? cnt_q : cnt_q - 1'b1;
  assign done = at_zero && !load;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule
`default_nettype wire

// file: core/pwc_clk_divider.sv
// Core clock enable generator dividing by a power of two
`timescale 1ns/10ps
`default_nettype none
module pwc_clk_divider #(
  parameter int unsigned DIV_W = 3
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Control
  input wire logic run,
  input wire logic [DIV_W-1:0] div_sel,
  // Output tick
  output logic tick
);

  localparam int unsigned CW = (1 << DIV_W);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] mask;
  logic tick_q;

  // Tick every 2^div_sel cycles
  assign mask = CW'((1 << div_sel) - 1);
  assign tick = tick_q;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= run ? cnt_q + 1'b1 : '0;
      tick_q <= run && ((cnt_q & mask) == '0);
    end
  end

endmodule
`default_nettype wire

// file: core/pwc_por_powerdown_ctrl.sv
// Power-on reset sequencer with power-down entry and wake control
`timescale 1ns/10ps
`default_nettype none
module pwc_por_powerdown_ctrl #(
  parameter int unsigned POR_CYC = pwc_pkg::POR_DELAY_CYC,
  parameter int unsigned XTAL_CYC = pwc_pkg::XTAL_DELAY_CYC,
  parameter int unsigned LOCK_CYC = pwc_pkg::LOCK_DELAY_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Supply comparators and reset pin
  input wire logic supply_high_var,
  input wire logic supply_above_thr,
  input wire logic supply_above_1v,
  input wire logic reset_pin,
  // Wake interrupt requests
  input wire pwc_pkg::pwc_wake_src_t wake_irq,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Chip control
  output logic chip_reset,
  output logic resume_req,
  output logic core_tick,
  output var pwc_pkg::pwc_power_ctl_t power_ctl,
  output logic [31:0] pll_mult
);

  typedef enum logic [2:0] {
    PWC_POR,
    PWC_RUN,
    PWC_DOWN,
    PWC_XTAL,
    PWC_LOCK
  } pwc_state_t;

  pwc_state_t state_q;
  pwc_state_t state_d;
  logic [7:0] pwr_ctrl_q;
  logic [7:0] pll_ctrl_q;
  logic [7:0] wake_en_q;
  logic [31:0] prdata_q;
  logic chip_reset_q;
  logic resume_q;
  logic locked_q;
  logic osc_stopped_q;
  logic held_q;

  // Supply held: threshold taken from supply_above_thr alone, reset whenever below it or below 1 V
  wire logic supply_ok = supply_above_thr;
  wire logic por_hold = !supply_above_1v || (held_q && !supply_ok);
  wire logic hard_reset = por_hold || reset_pin || !supply_ok;

  wire logic apb_access = psel && penable;
  wire logic apb_wr = apb_access && pwrite;
  wire logic sel_pwr = (paddr == pwc_pkg::PWR_CTRL_OFF);
  wire logic sel_pll = (paddr == pwc_pkg::PLL_CTRL_OFF);
  wire logic sel_wake = (paddr == pwc_pkg::WAKE_EN_OFF);
  wire logic sel_stat = (paddr == pwc_pkg::STATUS_OFF);
  wire logic addr_ok = sel_pwr || sel_pll || sel_wake || sel_stat;

  wire logic pd_req = apb_wr && sel_pwr &&
                      pwdata[pwc_pkg::PWR_DOWN_BIT];
  wire logic osc_sleep = pll_ctrl_q[pwc_pkg::OSC_SLEEP_BIT];
  wire logic tic_run = wake_en_q[pwc_pkg::TIC_RUN_BIT];

  // Wake sources, each gated by its enables
  wire logic tic_wake = wake_irq.tic_irq && !osc_sleep && tic_run &&
                        wake_en_q[pwc_pkg::TIC_IE_BIT];
  wire logic spi_wake = wake_irq.spi_irq &&
                        pwr_ctrl_q[pwc_pkg::SERIAL_WAKE_BIT] &&
                        wake_en_q[pwc_pkg::SPI_IE_BIT];
  wire logic ext0_wake = wake_irq.ext0_irq &&
                         pwr_ctrl_q[pwc_pkg::EXT0_WAKE_BIT] &&
                         wake_en_q[pwc_pkg::EXT0_IE_BIT];
  wire logic any_wake = tic_wake || spi_wake || ext0_wake;

  logic por_done;
  logic xtal_done;
  logic lock_done;
  logic in_down;

  assign in_down = (state_q == PWC_DOWN);

  // Held flag reloads too, so a release with good supply still waits
  pwc_delay_timer #(.WIDTH(32)) u_por_timer (
    .mclk(mclk),
    .reset_n(reset_n),
    .load(hard_reset || held_q),
    .load_val(32'(POR_CYC)),
    .hold(1'b0),
    .done(por_done)
  );

  // Separate timers: a lock reload must not feed back into crystal expiry
  wire logic wake_go = in_down && any_wake;
  wire logic xtal_load = wake_go && osc_stopped_q;
  wire logic lock_load = (wake_go && !osc_stopped_q) ||
                         ((state_q == PWC_XTAL) && xtal_done);

  pwc_delay_timer #(.WIDTH(32)) u_xtal_timer (
    .mclk(mclk),
    .reset_n(reset_n),
    .load(xtal_load),
    .load_val(32'(XTAL_CYC)),
    .hold(1'b0),
    .done(xtal_done)
  );

  pwc_delay_timer #(.WIDTH(32)) u_lock_timer (
    .mclk(mclk),
    .reset_n(reset_n),
    .load(lock_load),
    .load_val(32'(LOCK_CYC)),
    .hold(1'b0),
    .done(lock_done)
  );

  always_comb begin
    state_d = state_q;
    case (state_q)
      PWC_POR: begin
        if (!hard_reset && por_done) begin
          state_d = PWC_RUN;
        end
      end
      PWC_RUN: begin
        if (pd_req) begin
          state_d = PWC_DOWN;
        end
      end
      PWC_DOWN: begin
        if (any_wake) begin
          state_d = osc_stopped_q ? PWC_XTAL : PWC_LOCK;
        end
      end
      PWC_XTAL: begin
        if (xtal_done) begin
          state_d = PWC_LOCK;
        end
      end
      PWC_LOCK: begin
        if (lock_done) begin
          state_d = PWC_RUN;
        end else if (pd_req) begin
          state_d = PWC_DOWN;
        end
      end
      default: state_d = PWC_POR;
    endcase
    if (hard_reset) begin
      state_d = PWC_POR;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_q <= PWC_POR;
      held_q <= 1'b1;
    end else begin
      state_q <= state_d;
      held_q <= por_hold || !supply_ok;
    end
  end

  // Registers; any reset source restores defaults
  always_ff @(posedge mclk) begin
    if (!reset_n || hard_reset) begin
      pwr_ctrl_q <= pwc_pkg::PWR_CTRL_RST;
      pll_ctrl_q <= pwc_pkg::PLL_CTRL_RST;
      wake_en_q <= pwc_pkg::WAKE_EN_RST;
    end else begin
      if (apb_wr && sel_pwr) begin
        pwr_ctrl_q <= pwdata[7:0];
      end else if (state_q == PWC_DOWN && any_wake) begin
        pwr_ctrl_q[pwc_pkg::PWR_DOWN_BIT] <= 1'b0;
      end
      if (apb_wr && sel_pll) begin
        pll_ctrl_q <= pwdata[7:0];
      end
      if (apb_wr && sel_wake) begin
        wake_en_q <= pwdata[7:0];
      end
    end
  end

  // Lock flag, oscillator state, resume strobe
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      locked_q <= 1'b0;
      osc_stopped_q <= 1'b0;
      resume_q <= 1'b0;
      chip_reset_q <= 1'b1;
    end else begin
      chip_reset_q <= (state_d == PWC_POR);
      resume_q <= wake_go;
      if (state_d == PWC_DOWN || state_d == PWC_POR) begin
        locked_q <= 1'b0;
      end else if (state_q == PWC_LOCK && lock_done) begin
        locked_q <= 1'b1;
      end else if (state_q == PWC_POR && state_d == PWC_RUN) begin
        locked_q <= 1'b1;
      end
      if (pd_req) begin
        osc_stopped_q <= osc_sleep;
      end else if (state_q != PWC_DOWN) begin
        osc_stopped_q <= 1'b0;
      end
    end
  end

  wire logic [31:0] status_word = {26'h0, supply_high_var, locked_q,
                                   held_q, state_q};
  wire logic [7:0] pll_rd = {pll_ctrl_q[7], locked_q,
                             pll_ctrl_q[5:0]};
  wire logic [31:0] rd_mux = sel_pwr ? {24'h0, pwr_ctrl_q} :
                             sel_pll ? {24'h0, pll_rd} :
                             sel_wake ? {24'h0, wake_en_q} :
                             sel_stat ? status_word : 32'h0;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      prdata_q <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= rd_mux;
    end
  end

  // Zero-wait answer; unmapped addresses signal error
  assign pready = 1'b1;
  assign pslverr = apb_access && !addr_ok;
  assign prdata = prdata_q;

  pwc_clk_divider #(.DIV_W(pwc_pkg::CDIV_W)) u_div (
    .mclk(mclk),
    .reset_n(reset_n),
    .run(!in_down && state_q != PWC_POR),
    .div_sel(pll_ctrl_q[pwc_pkg::CDIV_LSB +: pwc_pkg::CDIV_W]),
    .tick(core_tick)
  );

  assign chip_reset = chip_reset_q;
  assign resume_req = resume_q;
  assign pll_mult = 32'(pwc_pkg::PLL_MULT);
  assign power_ctl.osc_run = !(in_down && osc_sleep) &&
                             !(state_q == PWC_XTAL &&
                               !xtal_done);
  assign power_ctl.pll_run = !in_down;
  assign power_ctl.core_clk_en = !in_down && !chip_reset_q;
  assign power_ctl.periph_en = !in_down;
  assign power_ctl.tic_en = tic_run && !(in_down && osc_sleep);
  assign power_ctl.dac_hiz = in_down;
  assign power_ctl.strobes_low = in_down;
  assign power_ctl.port_hold = in_down;

  // Checks
  sequence pd_write_s;
    state_q == PWC_RUN && pd_req && !hard_reset;
  endsequence

  pd_entry_a: assert property (@(posedge mclk) disable iff (!reset_n)
    pd_write_s |=> in_down) else $error("no power-down entry");
  pll_stop_a: assert property (@(posedge mclk) disable iff (!reset_n)
    in_down |-> !power_ctl.pll_run && !power_ctl.core_clk_en)
    else $error("pll runs in power-down");
  osc_sleep_a: assert property (@(posedge mclk) disable iff (!reset_n)
    in_down && osc_sleep |-> !power_ctl.osc_run)
    else $error("oscillator runs while asleep");
  pins_park_a: assert property (@(posedge mclk) disable iff (!reset_n)
    in_down |-> power_ctl.dac_hiz && power_ctl.strobes_low)
    else $error("pins not parked");
  rst_pin_a: assert property (@(posedge mclk) disable iff (!reset_n)
    reset_pin |=> state_q == PWC_POR && pwr_ctrl_q == 8'h00)
    else $error("reset pin ignored");
  spi_wake_a: assert property (@(posedge mclk) disable iff (!reset_n)
    in_down && spi_wake && !hard_reset |=> !in_down ##0 resume_q)
    else $error("spi wake lost");
  ext0_wake_a: assert property (@(posedge mclk) disable iff (!reset_n)
    in_down && wake_irq.ext0_irq &&
    !pwr_ctrl_q[pwc_pkg::EXT0_WAKE_BIT] && !tic_wake && !spi_wake &&
    !hard_reset
    |=> in_down) else $error("ext0 wake not gated");
  lock_low_a: assert property (@(posedge mclk) disable iff (!reset_n)
    pd_write_s |=> !locked_q [*2])
    else $error("lock flag high in power-down");

endmodule
`default_nettype wire

// file: tb/pwc_por_powerdown_ctrl_tb.sv
// Self-checking bench for the power-on reset and power-down controller
`timescale 1ns/10ps
`default_nettype none
module pwc_por_powerdown_ctrl_tb;
  // Short counts keep the run brief
  localparam int POR = 20;
  localparam int XT = 60;
  localparam int LK = 40;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic thr = 1'b0;
  logic v1 = 1'b0;
  logic rpin = 1'b0;
  pwc_pkg::pwc_wake_src_t irq = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic chip_reset;
  logic resume_req;
  logic core_tick;
  pwc_pkg::pwc_power_ctl_t power_ctl;
  logic [31:0] pll_mult;
  logic [31:0] rd;
  logic slv_err;
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;

  always #25 mclk = ~mclk;

  pwc_por_powerdown_ctrl #(.POR_CYC(POR), .XTAL_CYC(XT), .LOCK_CYC(LK))
  i_pwc_por_powerdown_ctrl (
    .mclk(mclk), .reset_n(reset_n), .supply_high_var(1'b0),
    .supply_above_thr(thr), .supply_above_1v(v1), .reset_pin(rpin),
    .wake_irq(irq), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chip_reset(chip_reset), .resume_req(resume_req),
    .core_tick(core_tick), .power_ctl(power_ctl), .pll_mult(pll_mult)
  );

  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      $display("ERROR %0t: timeout", $time);
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1);
    chk(k < 50, 1'b1);
    rd = prdata;
    slv_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdreg(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic cycles(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask

  // Cycles from now until chip_reset drops, bounded
  task automatic por_len(input int lo, input int hi);
    int k;
    k = 0;
    while (chip_reset === 1'b1 && k < hi + 5) begin
      cycles(1);
      k++;
    end
    chk(k >= lo && k <= hi, 1'b1);
  endtask

  task automatic ticks(input int c, input int exp);
    int k;
    k = 0;
    repeat (c) begin
      cycles(1);
      k += (core_tick === 1'b1);
    end
    chk(k, exp);
  endtask

  // Raise one wake source and count resume pulses
  task automatic wake(input pwc_pkg::pwc_wake_src_t s, input int exp);
    int k;
    k = 0;
    @(posedge mclk);
    irq <= s;
    repeat (4) begin
      cycles(1);
      k += (resume_req === 1'b1);
    end
    @(posedge mclk);
    irq <= '0;
    chk(k, exp);
  endtask

  // Lock flag low soon after wake, high once the delays run out
  task automatic lock_seq(input int extra);
    rdreg(pwc_pkg::PLL_CTRL_OFF);
    chk(rd[6], 1'b0);
    if (extra > 0) begin
      cycles(LK + 4);
      rdreg(pwc_pkg::PLL_CTRL_OFF);
      chk(rd[6], 1'b0);
    end
    cycles(LK + extra + 4);
    rdreg(pwc_pkg::PLL_CTRL_OFF);
    chk(rd[6], 1'b1);
  endtask

  initial begin
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    v1 <= 1'b1;
    cycles(10);
    chk(chip_reset, 1'b1);
    @(posedge mclk);
    thr <= 1'b1;
    por_len(POR - 1, POR + 4);
    chk(pll_mult, 32'h0000_0180);
    rdreg(pwc_pkg::PLL_CTRL_OFF);
    chk(rd, 32'h0000_0043);
    rdreg(pwc_pkg::PWR_CTRL_OFF);
    chk(rd, 32'h0000_0000);
    rdreg(8'h10);
    chk(slv_err, 1'b1);
    chk(rd, 32'h0000_0000);
    chk(power_ctl & 8'hF7, 8'hF0);
    for (int dv = 0; dv < 4; dv++) begin
      wr(pwc_pkg::PLL_CTRL_OFF, dv);
      cycles(8);
      ticks(64, 64 >> dv);
    end
    wr(pwc_pkg::PLL_CTRL_OFF, 32'h0000_0003);
    // Interval counter wake with oscillator running
    wr(pwc_pkg::WAKE_EN_OFF, 32'h0000_0009);
    wr(pwc_pkg::PWR_CTRL_OFF, 32'h0000_0002);
    cycles(2);
    chk(power_ctl, 8'h8F);
    ticks(16, 0);
    wake(3'b100, 1);
    chk(power_ctl & 8'hF7, 8'hF0);
    lock_seq(0);
    rdreg(pwc_pkg::PWR_CTRL_OFF);
    chk(rd, 32'h0000_0000);
    // Each wake bit gates only its own source
    wr(pwc_pkg::WAKE_EN_OFF, 32'h0000_0006);
    wr(pwc_pkg::PWR_CTRL_OFF, 32'h0000_0042);
    cycles(2);
    wake(3'b001, 0);
    chk(power_ctl, 8'h87);
    wake(3'b010, 1);
    lock_seq(0);
    wr(pwc_pkg::PWR_CTRL_OFF, 32'h0000_0022);
    cycles(2);
    wake(3'b010, 0);
    chk(power_ctl, 8'h87);
    wake(3'b001, 1);
    rdreg(pwc_pkg::PWR_CTRL_OFF);
    chk(rd, 32'h0000_0020);
    // Oscillator asleep adds the crystal start-up delay
    wr(pwc_pkg::PLL_CTRL_OFF, 32'h0000_000B);
    wr(pwc_pkg::WAKE_EN_OFF, 32'h0000_0004);
    wr(pwc_pkg::PWR_CTRL_OFF, 32'h0000_0022);
    cycles(2);
    chk(power_ctl, 8'h07);
    wake(3'b001, 1);
    lock_seq(XT);
    // Reset pin while powered down
    wr(pwc_pkg::PWR_CTRL_OFF, 32'h0000_0022);
    @(posedge mclk);
    rpin <= 1'b1;
    cycles(3);
    chk(chip_reset, 1'b1);
    @(posedge mclk);
    rpin <= 1'b0;
    por_len(POR - 1, POR + 4);
    rdreg(pwc_pkg::PWR_CTRL_OFF);
    chk(rd, 32'h0000_0000);
    rdreg(pwc_pkg::PLL_CTRL_OFF);
    chk(rd, 32'h0000_0043);
    // Supply falls, then cycles back up
    wr(pwc_pkg::WAKE_EN_OFF, 32'h0000_0005);
    @(posedge mclk);
    thr <= 1'b0;
    cycles(3);
    chk(chip_reset, 1'b1);
    cycles(POR + 5);
    chk(chip_reset, 1'b1);
    @(posedge mclk);
    v1 <= 1'b0;
    cycles(3);
    @(posedge mclk);
    v1 <= 1'b1;
    thr <= 1'b1;
    por_len(POR - 1, POR + 4);
    rdreg(pwc_pkg::WAKE_EN_OFF);
    chk(rd, 32'h0000_0000);
    end_sim();
  end
endmodule
`default_nettype wire
